// >>> hw/msf_pkg.sv
// How it works
// - Every block opens with ID character 0x40 then two station digits.
// - Station 1..127, sent as two upper-case hex digits, high nibble first.
// - Block: ID, station, start, 3-digit number, up to 255 chars, end, LRC.
// - Short message: one block numbered one, ended by end-of-text and LRC.
// - Long message: full 255-char blocks end-of-block, last one end-of-text.
// - Block numbers count up from one; last carries the block total.
// - Parameters are 16-bit signed values written as ASCII hex.
// - Module answers success '#' or failure '!' plus three-char code.
// - Each block gets ack or nak plus station digits; run after final ack.
// - Response is one addressed block numbered one, end-of-text, LRC.
// - LRC starts at 0xff and XORs start character through end character.
// - On a nak the sender repeats the same block, at most 5 times.
package msf_pkg;

    // ----------------------------------------------------------------
    // Link characters
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_ID    = 8'h40;
    localparam logic [7:0] CH_STX   = 8'h02;
    localparam logic [7:0] CH_ETX   = 8'h03;
    localparam logic [7:0] CH_ETB   = 8'h17;
    localparam logic [7:0] CH_ACK   = 8'h06;
    localparam logic [7:0] CH_NAK   = 8'h15;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_OK    = 8'h23;
    localparam logic [7:0] CH_FAIL  = 8'h21;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_NINE  = 8'h39;
    localparam logic [7:0] LRC_INIT = 8'hff;

    // ----------------------------------------------------------------
    // Counts and reset values
    // ----------------------------------------------------------------
    localparam logic [8:0] MSG_MAX     = 9'h0ff;
    localparam logic [1:0] BLK_LAST    = 2'h2;
    localparam logic [2:0] RETRY_MAX   = 3'h5;
    localparam logic [9:0] BLK_FIRST   = 10'h001;
    localparam int         FIFO_WIDTH  = 10;
    localparam int         FIFO_DEPTH  = 8;

    // ----------------------------------------------------------------
    // Response byte positions
    // ----------------------------------------------------------------
    localparam logic [3:0] POS_ACK_LAST = 4'h2;
    localparam logic [3:0] POS_LRC_FROM = 4'h3;
    localparam logic [3:0] POS_RESULT   = 4'h7;
    localparam logic [3:0] POS_CODE     = 4'h8;
    localparam logic [3:0] POS_ETX      = 4'hb;
    localparam logic [3:0] POS_LRC      = 4'hc;
    localparam logic [3:0] OK_SKIP      = 4'h3;

    // Word kinds handed to the command processor
    typedef enum logic [1:0] {
        MK_DATA    = 2'h0,
        MK_BLK_OK  = 2'h1,
        MK_BLK_BAD = 2'h2,
        MK_EXEC    = 2'h3
    } msf_mark_t;

    // Kinds of frame the transmitter sends
    typedef enum logic [1:0] {
        TK_ACK  = 2'h0,
        TK_NAK  = 2'h1,
        TK_RESP = 2'h2
    } msf_txkind_t;

    // Nibble to upper-case ASCII hex digit
    function automatic logic [7:0] hex_ascii(input logic [3:0] n);
        hex_ascii = (n < 4'ha) ? (CH_ZERO + {4'h0, n})
                               : (8'h37 + {4'h0, n});
    endfunction

endpackage

// >>> hw/msf_tx_if.sv
`timescale 1ns/1ns
// Request from the receive sequencer to the frame transmitter
interface msf_tx_if;
    import msf_pkg::*;
    logic        start;
    logic        busy;
    msf_txkind_t kind;
    logic        ok;
    logic [23:0] code;
    modport ctl (output start, kind, ok, code, input busy);
    modport tx  (input start, kind, ok, code, output busy);
endinterface

// >>> hw/msf_fifo.sv
`timescale 1ns/1ns
module msf_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Honest flags: full stalls the filler, empty hides the output
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and fill count update
    always_comb begin
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; empty flag hides stale words
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// >>> hw/msf_tx.sv
`timescale 1ns/1ns
module msf_tx
    import msf_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Request from the sequencer
    msf_tx_if.tx            req,
    // Own station
    input  wire logic [6:0] station,
    // Bytes to the UART
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    input  wire logic       tx_ready
);
    logic        busy_q, busy_d, ok_q, ok_d, v_q, v_d;
    msf_txkind_t kind_q, kind_d;
    logic [23:0] code_q, code_d;
    logic [3:0]  idx_q, idx_d, pos;
    logic [7:0]  lrc_q, lrc_d, d_q, d_d, byte_now;
    logic        last, take;

    assign req.busy = busy_q || v_q;
    assign tx_valid = v_q;
    assign tx_data  = d_q;

    // Byte selection; a success reply skips the three code positions
    always_comb begin
        pos = idx_q;
        if (kind_q == TK_RESP && ok_q && idx_q >= POS_CODE) begin
            pos = 4'(idx_q + OK_SKIP);
        end
        byte_now = lrc_q;
        if (kind_q != TK_RESP) begin
            unique case (pos)
                4'h0: byte_now = (kind_q == TK_NAK) ? CH_NAK : CH_ACK;
                4'h1: byte_now = hex_ascii({1'b0, station[6:4]});
                default: byte_now = hex_ascii(station[3:0]);
            endcase
            last = (pos == POS_ACK_LAST);
        end else begin
            unique case (pos)
                4'h0: byte_now = CH_ID;
                4'h1: byte_now = hex_ascii({1'b0, station[6:4]});
                4'h2: byte_now = hex_ascii(station[3:0]);
                4'h3: byte_now = CH_STX;
                4'h4: byte_now = CH_ZERO;
                4'h5: byte_now = CH_ZERO;
                4'h6: byte_now = CH_ONE;
                4'h7: byte_now = ok_q ? CH_OK : CH_FAIL;
                4'h8: byte_now = code_q[23:16];
                4'h9: byte_now = code_q[15:8];
                4'ha: byte_now = code_q[7:0];
                4'hb: byte_now = CH_ETX;
                default: byte_now = lrc_q;
            endcase
            last = (pos == POS_LRC);
        end
    end

    // Sequencing: one byte loaded each time the output register frees
    always_comb begin
        take   = busy_q && (!v_q || tx_ready);
        busy_d = busy_q;
        kind_d = kind_q;
        ok_d   = ok_q;
        code_d = code_q;
        idx_d  = idx_q;
        lrc_d  = lrc_q;
        v_d    = v_q;
        d_d    = d_q;
        if (v_q && tx_ready) begin
            v_d = 1'b0;
        end
        if (!busy_q && req.start) begin
            busy_d = 1'b1;
            kind_d = req.kind;
            ok_d   = req.ok;
            code_d = req.code;
            idx_d  = '0;
            lrc_d  = LRC_INIT;
        end else if (take) begin
            v_d   = 1'b1;
            d_d   = byte_now;
            idx_d = 4'(idx_q + 1'b1);
            if (pos >= POS_LRC_FROM && pos <= POS_ETX) begin
                lrc_d = lrc_q ^ byte_now;
            end
            if (last) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            kind_q <= TK_ACK;
            ok_q   <= 1'b0;
            code_q <= '0;
            idx_q  <= '0;
            lrc_q  <= LRC_INIT;
            v_q    <= 1'b0;
            d_q    <= '0;
        end else begin
            busy_q <= busy_d;
            kind_q <= kind_d;
            ok_q   <= ok_d;
            code_q <= code_d;
            idx_q  <= idx_d;
            lrc_q  <= lrc_d;
            v_q    <= v_d;
            d_q    <= d_d;
        end
    end
endmodule

// >>> hw/msf_framer.sv
`timescale 1ns/1ns
module msf_framer
    import msf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Received bytes from the UART
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // Bytes to the UART
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    // Configuration
    input  wire logic [6:0]  station_id,
    // Message words toward the command processor
    output logic             msg_valid,
    input  wire logic        msg_ready,
    output logic [7:0]       msg_data,
    output logic [1:0]       msg_mark,
    // Command result from the command processor
    input  wire logic        result_valid,
    output logic             result_ready,
    input  wire logic        result_ok,
    input  wire logic [23:0] result_code,
    // Status
    output logic             resp_failed
);
    // ----------------------------------------------------------------
    // Receive sequencer state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        R_HUNT     = 4'h0,
        R_ADDR_H   = 4'h1,
        R_ADDR_L   = 4'h2,
        R_SKIP     = 4'h3,
        R_SKIP_LRC = 4'h4,
        R_STX      = 4'h5,
        R_BLK      = 4'h6,
        R_DATA     = 4'h7,
        R_LRC      = 4'h8,
        R_ACK      = 4'h9,
        R_MARK     = 4'ha,
        R_EXEC     = 4'hb,
        R_RESP     = 4'hc,
        R_HOST     = 4'hd
    } msf_rstate_t;

    msf_rstate_t st_q, st_d;
    logic [7:0]  lrc_q, lrc_d;
    logic [8:0]  cnt_q, cnt_d;
    logic [9:0]  num_q, num_d, exp_q, exp_d;
    logic [1:0]  dig_q, dig_d;
    logic        err_q, err_d, fin_q, fin_d;
    logic [2:0]  retry_q, retry_d;
    logic        rok_q, rok_d, fail_q, fail_d;
    logic [23:0] rcode_q, rcode_d;

    logic [7:0]  st_hi, st_lo;
    logic        is_digit, is_end;
    logic [13:0] num_ext;
    logic        fifo_in_valid, fifo_in_ready;
    logic [FIFO_WIDTH-1:0] fifo_in_data, fifo_out_data;

    msf_tx_if txr ();

    // ----------------------------------------------------------------
    // Leaf blocks
    // ----------------------------------------------------------------
    // Message path; full FIFO turns a data byte into a refused block
    msf_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (msg_valid),
        .out_ready (msg_ready),
        .out_data  (fifo_out_data)
    );

    msf_tx u_tx (
        .clk      (clk),
        .reset_n  (reset_n),
        .req      (txr.tx),
        .station  (station_id),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .tx_ready (tx_ready)
    );

    assign msg_mark    = fifo_out_data[9:8];
    assign msg_data    = fifo_out_data[7:0];
    assign resp_failed = fail_q;

    // Own station digits and character classes
    assign st_hi    = hex_ascii({1'b0, station_id[6:4]});
    assign st_lo    = hex_ascii(station_id[3:0]);
    assign is_digit = (rx_data >= CH_ZERO) && (rx_data <= CH_NINE);
    assign is_end   = (rx_data == CH_ETX) || (rx_data == CH_ETB);
    assign num_ext  = 14'({num_q, 3'h0}) + 14'({num_q, 1'b0})
                    + 14'(rx_data[3:0]);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Bytes arriving while a reply is pending are ignored: the link
    // is half duplex and the host may not talk over the module.
    always_comb begin
        st_d          = st_q;
        lrc_d         = lrc_q;
        cnt_d         = cnt_q;
        num_d         = num_q;
        exp_d         = exp_q;
        dig_d         = dig_q;
        err_d         = err_q;
        fin_d         = fin_q;
        retry_d       = retry_q;
        rok_d         = rok_q;
        rcode_d       = rcode_q;
        fail_d        = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_in_data  = {MK_DATA, rx_data};
        result_ready  = 1'b0;
        txr.start     = 1'b0;
        txr.kind      = err_q ? TK_NAK : TK_ACK;
        txr.ok        = rok_q;
        txr.code      = rcode_q;
        unique case (st_q)
            R_HUNT: begin
                if (rx_valid && rx_data == CH_ID) begin
                    st_d = R_ADDR_H;
                end
            end
            R_ADDR_H: begin
                if (rx_valid) begin
                    st_d = (rx_data == st_hi) ? R_ADDR_L : R_SKIP;
                end
            end
            R_ADDR_L: begin
                if (rx_valid) begin
                    st_d = (rx_data == st_lo) ? R_STX : R_SKIP;
                end
            end
            R_SKIP: begin
                // Another station's block: swallow it up to its LRC
                if (rx_valid && is_end) begin
                    st_d = R_SKIP_LRC;
                end
            end
            R_SKIP_LRC: begin
                if (rx_valid) begin
                    st_d = R_HUNT;
                end
            end
            R_STX: begin
                if (rx_valid) begin
                    st_d  = (rx_data == CH_STX) ? R_BLK : R_HUNT;
                    lrc_d = LRC_INIT ^ rx_data;
                    num_d = '0;
                    dig_d = '0;
                    cnt_d = '0;
                    err_d = 1'b0;
                end
            end
            R_BLK: begin
                if (rx_valid) begin
                    lrc_d = lrc_q ^ rx_data;
                    num_d = num_ext[9:0];
                    dig_d = 2'(dig_q + 1'b1);
                    if (!is_digit) begin
                        err_d = 1'b1;
                    end
                    if (dig_q == BLK_LAST) begin
                        st_d = R_DATA;
                    end
                end
            end
            R_DATA: begin
                if (rx_valid) begin
                    lrc_d = lrc_q ^ rx_data;
                    if (is_end) begin
                        st_d  = R_LRC;
                        fin_d = (rx_data == CH_ETX);
                        if (rx_data == CH_ETB && cnt_q != MSG_MAX) begin
                            err_d = 1'b1;
                        end
                        if (num_q != exp_q && num_q != BLK_FIRST) begin
                            err_d = 1'b1;
                        end
                    end else begin
                        cnt_d         = 9'(cnt_q + 1'b1);
                        fifo_in_valid = (cnt_q != MSG_MAX);
                        if (cnt_q == MSG_MAX || !fifo_in_ready) begin
                            err_d = 1'b1;
                        end
                        // Control command opens with a space
                        if (cnt_q == '0 && num_q == BLK_FIRST
                                && rx_data != CH_SPACE) begin
                            err_d = 1'b1;
                        end
                    end
                end
            end
            R_LRC: begin
                if (rx_valid) begin
                    if (rx_data != lrc_q) begin
                        err_d = 1'b1;
                    end
                    st_d = R_ACK;
                end
            end
            R_ACK: begin
                if (!txr.busy) begin
                    txr.start = 1'b1;
                    st_d      = R_MARK;
                end
            end
            R_MARK: begin
                // Marker waits for the ack to leave, so execution never
                // starts before the final block is acknowledged.
                fifo_in_valid = !txr.busy;
                fifo_in_data  = {err_q ? MK_BLK_BAD
                                 : (fin_q ? MK_EXEC : MK_BLK_OK), 8'h00};
                if (!txr.busy && fifo_in_ready) begin
                    if (err_q) begin
                        st_d = R_HUNT;
                    end else if (fin_q) begin
                        exp_d = BLK_FIRST;
                        st_d  = R_EXEC;
                    end else begin
                        exp_d = 10'(num_q + 1'b1);
                        st_d  = R_HUNT;
                    end
                end
            end
            R_EXEC: begin
                result_ready = 1'b1;
                if (result_valid) begin
                    rok_d   = result_ok;
                    rcode_d = result_code;
                    retry_d = '0;
                    st_d    = R_RESP;
                end
            end
            R_RESP: begin
                txr.kind = TK_RESP;
                if (!txr.busy) begin
                    txr.start = 1'b1;
                    st_d      = R_HOST;
                end
            end
            R_HOST: begin
                if (rx_valid) begin
                    if (rx_data == CH_ACK) begin
                        st_d = R_HUNT;
                    end else if (rx_data == CH_NAK) begin
                        if (retry_q < RETRY_MAX) begin
                            retry_d = 3'(retry_q + 1'b1);
                            st_d    = R_RESP;
                        end else begin
                            fail_d = 1'b1;
                            st_d   = R_HUNT;
                        end
                    end else if (rx_data == CH_ID) begin
                        st_d = R_ADDR_H;
                    end
                end
            end
            default: begin
                st_d = R_HUNT;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q    <= R_HUNT;
            lrc_q   <= LRC_INIT;
            cnt_q   <= '0;
            num_q   <= '0;
            exp_q   <= BLK_FIRST;
            dig_q   <= '0;
            err_q   <= 1'b0;
            fin_q   <= 1'b0;
            retry_q <= '0;
            rok_q   <= 1'b0;
            rcode_q <= '0;
            fail_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            lrc_q   <= lrc_d;
            cnt_q   <= cnt_d;
            num_q   <= num_d;
            exp_q   <= exp_d;
            dig_q   <= dig_d;
            err_q   <= err_d;
            fin_q   <= fin_d;
            retry_q <= retry_d;
            rok_q   <= rok_d;
            rcode_q <= rcode_d;
            fail_q  <= fail_d;
        end
    end
endmodule

// >>> testbench/msf_framer_props.sv
`timescale 1ns/1ns
module msf_framer_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Link transmit side
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_ready,
    input wire logic [6:0] station_id,
    // Command processor side
    input wire logic       msg_valid,
    input wire logic       msg_ready,
    input wire logic [7:0] msg_data,
    input wire logic [1:0] msg_mark,
    input wire logic       result_valid,
    input wire logic       result_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] hi;
    logic       acc, took;
    // High station digit is always a decimal digit, station below 128
    assign hi   = 8'h30 + {5'h0, station_id[6:4]};
    assign acc  = tx_valid && tx_ready;
    assign took = result_valid && result_ready;
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("tx byte changed before taken");
    property p_rst; $rose(reset_n) |-> !tx_valid && !result_ready; endproperty
    a_rst: assert property (p_rst)
        else $error("outputs busy after reset");
    property p_id; acc && tx_data == 8'h40 |-> ##[1:2] tx_valid && tx_data == hi;
    endproperty
    a_id: assert property (p_id)
        else $error("station digit missing after id");
    property p_ack; acc && (tx_data == 8'h06 || tx_data == 8'h15)
        |-> ##[1:2] tx_valid && tx_data == hi; endproperty
    a_ack: assert property (p_ack)
        else $error("station digit missing after ack");
    property p_resp; took |-> ##3 tx_valid && tx_data == 8'h40; endproperty
    a_resp: assert property (p_resp)
        else $error("response frame late");
    property p_msg; msg_valid && !msg_ready |=> msg_valid && $stable(msg_data)
        && $stable(msg_mark); endproperty
    a_msg: assert property (p_msg)
        else $error("message word dropped");
    property p_once; took |=> !result_ready; endproperty
    a_once: assert property (p_once)
        else $error("result taken twice");
    property p_quiet; result_ready |-> !tx_valid; endproperty
    a_quiet: assert property (p_quiet)
        else $error("sending while awaiting result");
    c_resp: cover property (took);
    c_nak: cover property (acc && tx_data == 8'h15);
    c_stall: cover property (msg_valid && !msg_ready);
endmodule
bind msf_framer msf_framer_props u_props (.clk, .reset_n, .tx_valid,
    .tx_data, .tx_ready, .station_id, .msg_valid, .msg_ready, .msg_data,
    .msg_mark, .result_valid, .result_ready);

// >>> testbench/msf_host_model.sv
`timescale 1ns/1ns
module msf_host_model (
    // Clock and link
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic stall,
    // Byte handshake
    output logic     tx_ready,
    output logic     got
);
    // Ready moves on the falling edge so sampling never races it
    initial tx_ready = 1'b0;
    always @(negedge clk) tx_ready <= !stall;
    assign got = tx_valid && tx_ready;
endmodule

// >>> testbench/msf_framer_bench.sv
`timescale 1ns/1ns
module msf_framer_bench;
    logic        clk, reset_n, rx_valid, tx_valid, tx_ready, got;
    logic        msg_valid, msg_ready, result_valid, result_ready;
    logic        result_ok, resp_failed;
    logic [1:0]  msg_mark;
    logic [7:0]  rx_data, tx_data, msg_data, el;
    logic [23:0] result_code;
    logic [16:0] seed, rs;
    logic [7:0]  q[$];
    logic [9:0]  mq[$];
    int          n_errors = 0, check_count = 0, cyc = 0, nf = 0;
    msf_framer DUT (.clk, .reset_n, .rx_valid, .rx_data, .tx_valid,
        .tx_data, .tx_ready, .station_id(7'h7f), .msg_valid, .msg_ready,
        .msg_data, .msg_mark, .result_valid, .result_ready, .result_ok,
        .result_code, .resp_failed);
    msf_host_model host (.clk, .tx_valid, .stall(rs[1] & rs[2]),
        .tx_ready, .got);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        lfsr = {s[15:0], s[16] ^ s[13]};
    endfunction
    // Three-bit-wide drain keeps the FIFO from ever filling
    always @(negedge clk) begin
        rs        <= lfsr(rs);
        msg_ready <= rs[3] | rs[4] | rs[5];
    end
    task automatic finish_test;
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Every byte the host takes is checked against the oldest note
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            $display("ERROR %0t: timeout", $time);
            finish_test;
        end
        if (reset_n && resp_failed) nf++;
        if (reset_n && msg_valid && msg_ready) begin
            check_count++;
            if (!mq.size() || mq[0] !== {msg_mark, msg_data}) begin
                n_errors++;
                $display("ERROR %0t: bad message word %h", $time, msg_data);
            end
            if (mq.size() != 0) void'(mq.pop_front());
        end
        if (reset_n && got) begin
            check_count++;
            if (q.size() == 0 || q[0] !== tx_data) begin
                n_errors++;
                $display("ERROR %0t: bad tx byte %h", $time, tx_data);
            end
            if (q.size() != 0) void'(q.pop_front());
        end
    end
    // One byte per pulse, idle cycle between bytes
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data  = b;
        @(negedge clk);
        rx_valid = 1'b0;
    endtask
    task automatic drain;
        for (int k = 0; k < 4000 && q.size() != 0; k++) @(posedge clk);
        repeat (30) @(posedge clk);
        if (q.size() + mq.size() != 0) begin
            n_errors++;
            $display("ERROR %0t: reply missing", $time);
        end
    endtask
    task automatic e(input logic [7:0] b);
        q.push_back(b);
        el = el ^ b;
    endtask
    task automatic frame(input logic ok, input logic [23:0] cd);
        e(8'h40);
        e(8'h37);
        e(8'h46);
        el = 8'hff;
        e(8'h02);
        e(8'h30);
        e(8'h30);
        e(8'h31);
        e(ok ? 8'h23 : 8'h21);
        if (!ok) begin
            e(cd[23:16]);
            e(cd[15:8]);
            e(cd[7:0]);
        end
        e(8'h03);
        q.push_back(el);
    endtask
    task automatic blk(input logic [7:0] sl, num, ec, ack, input int n,
                       input logic bad);
        logic [7:0] c, l;
        l = 8'hff;
        put(8'h40);
        put(8'h37);
        put(sl);
        for (int i = 0; i <= n + 4; i++) begin
            seed = lfsr(seed);
            c = i == 0 ? 8'h02 : i < 3 ? 8'h30 : i == 3 ? num :
                i == n + 4 ? ec : (i == 4 && num == 8'h31) ? 8'h20 :
                8'h41 + {6'h0, seed[1:0]};
            l = l ^ c;
            if (ack != 8'h00 && i > 3 && i < n + 4) mq.push_back({2'h0, c});
            put(c);
        end
        if (ack != 8'h00) begin
            q.push_back(ack);
            q.push_back(8'h37);
            q.push_back(8'h46);
            mq.push_back({ack == 8'h15 ? 2'h2
                          : ec == 8'h03 ? 2'h3 : 2'h1, 8'h00});
        end
        put(bad ? ~l : l);
        drain;
    endtask
    // Answer the result, refuse the response nk times, then accept it
    task automatic res(input logic ok, input logic [23:0] cd, input int nk);
        for (int k = 0; k < 300 && !result_ready; k++) @(negedge clk);
        result_valid = 1'b1;
        result_ok    = ok;
        result_code  = cd;
        frame(ok, cd);
        @(negedge clk);
        result_valid = 1'b0;
        drain;
        for (int r = 0; r < nk; r++) begin
            if (r < 5) frame(ok, cd);
            put(8'h15);
            drain;
        end
        check_count++;
        if (nf != int'(nk > 5)) begin
            n_errors++;
            $display("ERROR %0t: bad failure pulse count", $time);
        end
        put(8'h06);
        drain;
    endtask
    initial begin
        {rx_valid, rx_data, result_valid, result_ok, result_code} = '0;
        seed      = 17'h123fa;
        rs        = 17'h123fa;
        msg_ready = 1'b1;
        reset_n   = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        blk(8'h46, 8'h31, 8'h03, 8'h06, 4, 1'b0);
        res(1'b1, 24'h0, 1);
        blk(8'h46, 8'h31, 8'h03, 8'h15, 4, 1'b1);
        blk(8'h46, 8'h31, 8'h17, 8'h06, 255, 1'b0);
        blk(8'h46, 8'h32, 8'h03, 8'h06, 3, 1'b0);
        res(1'b0, 24'h453031, 6);
        blk(8'h31, 8'h31, 8'h03, 8'h00, 4, 1'b0);
        finish_test;
    end
endmodule
